/* File: hdl/rtcb_pkg.sv */
// Constants and register map of the clock register bank
package rtcb_pkg;
    // Wishbone byte address width
    localparam int ADR_W = 19;
    // Register indices; byte address is four times these
    localparam logic [16:0] IDX_FLAGS = 17'h1fff0;
    localparam logic [16:0] IDX_CENT  = 17'h1fff1;
    localparam logic [16:0] IDX_ASEC  = 17'h1fff2;
    localparam logic [16:0] IDX_AMIN  = 17'h1fff3;
    localparam logic [16:0] IDX_AHR   = 17'h1fff4;
    localparam logic [16:0] IDX_ADATE = 17'h1fff5;
    localparam logic [16:0] IDX_IRQ   = 17'h1fff6;
    localparam logic [16:0] IDX_DOG   = 17'h1fff7;
    localparam logic [16:0] IDX_TRIM  = 17'h1fff8;
    localparam logic [16:0] IDX_SEC   = 17'h1fff9;
    localparam logic [16:0] IDX_MIN   = 17'h1fffa;
    localparam logic [16:0] IDX_HR    = 17'h1fffb;
    localparam logic [16:0] IDX_WDAY  = 17'h1fffc;
    localparam logic [16:0] IDX_DATE  = 17'h1fffd;
    localparam logic [16:0] IDX_MON   = 17'h1fffe;
    localparam logic [16:0] IDX_YEAR  = 17'h1ffff;
    // Field positions
    localparam int B_DOG_FLAG  = 7;  // dog_timeout_flag
    localparam int B_ALM_FLAG  = 6;  // alarm_flag
    localparam int B_PF_FLAG   = 5;  // power_fail_flag
    localparam int B_OSC_FLAG  = 4;  // oscillator_fail_flag
    localparam int B_ALM_WEN   = 1;  // alarm write-enable bit
    localparam int B_DOG_LOCK  = 6;  // dog_value_write_lock
    localparam int B_DOG_STB   = 7;  // dog_restart_strobe
    localparam int B_MSEL      = 7;  // alarm match-select
    localparam int B_OSC_RUN   = 7;  // oscillator stop bit, clear to run
    // Reset values, index 15 (year) down to 0 (flags)
    localparam logic [15:0][7:0] RST_TBL = {
        8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h08, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h10};
    // Writable bits per register, same order
    localparam logic [15:0][7:0] WMASK = {
        8'hff, 8'h1f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f, 8'hbf,
        8'hff, 8'hec, 8'hbf, 8'hbf, 8'hff, 8'hff, 8'hff, 8'h07};
    // BCD limits
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_07 = 8'h07;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;
    // Tick periods and derived cycle counts
    localparam int CLK_PERIOD_NS = 40;
    localparam int SEC_PERIOD_NS = 1_000_000_000;
    localparam int DOG_PERIOD_NS = 31_250_000;
    localparam int SEC_CYC = SEC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DOG_CYC = DOG_PERIOD_NS / CLK_PERIOD_NS;
endpackage : rtcb_pkg

/* File: hdl/rtcb_top.sv */
// Clock register bank with Wishbone slave, timekeeping and flags
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module rtcb_top #(
    parameter int unsigned SEC_CYC_P = rtcb_pkg::SEC_CYC,
    parameter int unsigned DOG_CYC_P = rtcb_pkg::DOG_CYC
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       srst,
    // Wishbone slave
    input  wire logic [rtcb_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_we_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // Event sources
    input  wire logic                       pwr_fail,
    input  wire logic                       osc_fail,
    // Interrupt
    output logic                            irq_o
);
    import rtcb_pkg::*;

    // Register bank indexed by word address
    logic [7:0]  bank_r   [IDX_FLAGS:IDX_YEAR];
    logic [7:0]  bank_nxt [IDX_FLAGS:IDX_YEAR];
    // Bus answer
    logic        ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    // Tick prescalers
    logic [31:0] sec_cnt_r, sec_cnt_nxt;
    logic [31:0] dog_div_r, dog_div_nxt;
    // Watchdog down counter
    logic [5:0]  dog_cnt_r, dog_cnt_nxt;
    // Edge memories and interrupt
    logic        pf_prev_r, pf_prev_nxt;
    logic        am_prev_r, am_prev_nxt;
    logic        irq_r, irq_nxt;

    // Decoded access
    logic [16:0] widx;
    logic        hit, req, wr, rd, rd_flags;
    // Ticks and carries
    logic        osc_run, sec_tick, dog_tick;
    logic        c_sec, c_min, c_hr, c_day, c_mon, c_yr;
    // Events
    logic        dog_exp, alm_on, alm_match, alm_rise, pf_rise;
    logic [5:0]  dog_val;
    logic [7:0]  flags_w, trim_w;

    // Next BCD value, wrapping to lo past hi
    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        if (v >= hi) begin
            bcd_inc = lo;
        end else if (v[3:0] >= 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction : bcd_inc

    // Last date of a month, leap years every fourth year
    function automatic logic [7:0] month_last(input logic [7:0] mon,
                                              input logic [7:0] yr);
        logic [1:0] m4;
        m4 = {yr[4], 1'b0} + yr[1:0];
        case (mon)
            8'h02:                      month_last = (m4 == 2'b00) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default:                    month_last = 8'h31;
        endcase
    endfunction : month_last

    // One alarm field agrees or is excluded
    function automatic logic fld_ok(input logic [7:0] alm, input logic [7:0] t);
        fld_ok = alm[B_MSEL] | (alm[6:0] == t[6:0]);
    endfunction : fld_ok

    // Address decode; only the top sixteen words belong here
    assign widx     = wb_adr_i[ADR_W-1:2];
    assign hit      = (widx >= IDX_FLAGS);
    assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr       = req & wb_we_i & wb_sel_i[0] & hit;
    assign rd       = req & ~wb_we_i & hit;
    assign rd_flags = rd && (widx == IDX_FLAGS);
    assign flags_w  = bank_r[IDX_FLAGS];
    assign trim_w   = bank_r[IDX_TRIM];

    // Oscillator runs while its bit is clear
    assign osc_run  = ~bank_r[IDX_TRIM][B_OSC_RUN];
    assign sec_tick = osc_run && (sec_cnt_r == SEC_CYC_P - 1);
    assign dog_tick = osc_run && (dog_div_r == DOG_CYC_P - 1);

    // Carry chain of the calendar
    assign c_sec = sec_tick && (bank_r[IDX_SEC] >= BCD_59);
    assign c_min = c_sec && (bank_r[IDX_MIN] >= BCD_59);
    assign c_hr  = c_min && (bank_r[IDX_HR] >= BCD_23);
    assign c_day = c_hr && (bank_r[IDX_DATE] >=
                   month_last(bank_r[IDX_MON], bank_r[IDX_YEAR]));
    assign c_mon = c_day && (bank_r[IDX_MON] >= BCD_12);
    assign c_yr  = c_mon && (bank_r[IDX_YEAR] >= BCD_99);

    // Alarm compare, held off while the host edits it
    assign alm_on = ~(bank_r[IDX_ASEC][B_MSEL] & bank_r[IDX_AMIN][B_MSEL]
                    & bank_r[IDX_AHR][B_MSEL] & bank_r[IDX_ADATE][B_MSEL]);
    assign alm_match = alm_on && !flags_w[B_ALM_WEN]
                       && fld_ok(bank_r[IDX_ASEC], bank_r[IDX_SEC])
                       && fld_ok(bank_r[IDX_AMIN], bank_r[IDX_MIN])
                       && fld_ok(bank_r[IDX_AHR], bank_r[IDX_HR])
                       && fld_ok(bank_r[IDX_ADATE], bank_r[IDX_DATE]);
    assign alm_rise = alm_match & ~am_prev_r;
    assign pf_rise  = pwr_fail & ~pf_prev_r;

    // Watchdog expiry on the tick that reaches zero
    assign dog_val = bank_r[IDX_DOG][5:0];
    assign dog_exp = dog_tick && (dog_val != 6'h00) && (dog_cnt_r == 6'h01);

    // Prescaler next values
    always_comb begin
        sec_cnt_nxt = (!osc_run || sec_tick) ? 32'h0 : sec_cnt_r + 32'h1;
        dog_div_nxt = (!osc_run || dog_tick) ? 32'h0 : dog_div_r + 32'h1;
    end

    // Prescaler registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sec_cnt_r <= 32'h0;
            dog_div_r <= 32'h0;
        end else begin
            sec_cnt_r <= sec_cnt_nxt;
            dog_div_r <= dog_div_nxt;
        end
    end

    // Register bank next values
    always_comb begin
        for (int i = IDX_FLAGS; i <= IDX_YEAR; i++) begin
            bank_nxt[i] = bank_r[i];
        end
        // Calendar advance in BCD
        if (sec_tick) begin
            bank_nxt[IDX_SEC] = bcd_inc(bank_r[IDX_SEC], BCD_00, BCD_59);
        end
        if (c_sec) begin
            bank_nxt[IDX_MIN] = bcd_inc(bank_r[IDX_MIN], BCD_00, BCD_59);
        end
        if (c_min) begin
            bank_nxt[IDX_HR] = bcd_inc(bank_r[IDX_HR], BCD_00, BCD_23);
        end
        if (c_hr) begin
            bank_nxt[IDX_WDAY] = bcd_inc(bank_r[IDX_WDAY], BCD_01, BCD_07);
            // Units 0-9, tens 0-3
            bank_nxt[IDX_DATE] = bcd_inc(bank_r[IDX_DATE], BCD_01,
                month_last(bank_r[IDX_MON], bank_r[IDX_YEAR]));
        end
        if (c_day) begin
            bank_nxt[IDX_MON] = bcd_inc(bank_r[IDX_MON], BCD_01, BCD_12);
        end
        if (c_mon) begin
            bank_nxt[IDX_YEAR] = bcd_inc(bank_r[IDX_YEAR], BCD_00, BCD_99);
        end
        if (c_yr) begin
            bank_nxt[IDX_CENT] = bcd_inc(bank_r[IDX_CENT], BCD_00, BCD_99);
        end
        // Reading the flags clears the watchdog, alarm and power-fail flags
        if (rd_flags) begin
            bank_nxt[IDX_FLAGS][7:5] = 3'b000;
        end
        // Host writes, low byte only
        if (wr) begin
            if (widx == IDX_FLAGS) begin
                // Event flags also clear on a written one
                bank_nxt[IDX_FLAGS][7:4] = bank_nxt[IDX_FLAGS][7:4] & ~wb_dat_i[7:4];
                bank_nxt[IDX_FLAGS][2:0] = wb_dat_i[2:0];
            end else if (widx == IDX_DOG) begin
                // Lock bit guards the binary timeout value
                bank_nxt[IDX_DOG][B_DOG_LOCK] = wb_dat_i[B_DOG_LOCK];
                if (!wb_dat_i[B_DOG_LOCK]) begin
                    bank_nxt[IDX_DOG][5:0] = wb_dat_i[5:0];
                end
            end else begin
                // Reserved bits stay zero
                bank_nxt[widx] = wb_dat_i[7:0] & WMASK[widx[3:0]];
            end
        end
        // Events set last so a set beats a clear
        if (dog_exp) begin
            bank_nxt[IDX_FLAGS][B_DOG_FLAG] = 1'b1;
        end
        if (alm_rise) begin
            bank_nxt[IDX_FLAGS][B_ALM_FLAG] = 1'b1;
        end
        if (pf_rise) begin
            bank_nxt[IDX_FLAGS][B_PF_FLAG] = 1'b1;
        end
        if (osc_fail) begin
            bank_nxt[IDX_FLAGS][B_OSC_FLAG] = 1'b1;
        end
    end

    // Register bank storage with its reset image
    always_ff @(posedge clk_sys) begin
        for (int i = IDX_FLAGS; i <= IDX_YEAR; i++) begin
            if (srst) begin
                bank_r[i] <= RST_TBL[4'(i)];
            end else begin
                bank_r[i] <= bank_nxt[i];
            end
        end
    end

    // Watchdog counter next value
    always_comb begin
        dog_cnt_nxt = dog_cnt_r;
        if (wr && (widx == IDX_DOG) && wb_dat_i[B_DOG_STB]) begin
            // Strobe restarts from the value now in force
            dog_cnt_nxt = bank_nxt[IDX_DOG][5:0];
        end else if (dog_tick && (dog_val != 6'h00)) begin
            // Reload at the end, else count down
            dog_cnt_nxt = (dog_cnt_r <= 6'h01) ? dog_val : dog_cnt_r - 6'h01;
        end
    end

    // Watchdog counter register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dog_cnt_r <= 6'h00;
        end else begin
            dog_cnt_r <= dog_cnt_nxt;
        end
    end

    // Edge memories and interrupt level
    always_comb begin
        pf_prev_nxt = pwr_fail;
        am_prev_nxt = alm_match;
        // Enables share bit positions with the flags
        irq_nxt = |(bank_nxt[IDX_FLAGS][7:5] & bank_nxt[IDX_IRQ][7:5]);
    end

    // Edge and interrupt registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pf_prev_r <= 1'b0;
            am_prev_r <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            pf_prev_r <= pf_prev_nxt;
            am_prev_r <= am_prev_nxt;
            irq_r     <= irq_nxt;
        end
    end

    // Bus answer: one-cycle ack, zero for unmapped reads
    always_comb begin
        ack_nxt = req;
        dat_nxt = dat_r;
        if (req && !wb_we_i) begin
            if (hit) begin
                dat_nxt = {24'h0, bank_r[widx]};
            end else begin
                dat_nxt = 32'h0;
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // Outputs straight from flops
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o    = irq_r;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    rd_value_a: assert property (rd_flags |=> wb_dat_o[7:0] == $past(flags_w))
        else $error("flag read data wrong");
    rd_clear_a: assert property ((rd_flags && !dog_exp && !alm_rise && !pf_rise)
        |=> flags_w[7:5] == 3'b000)
        else $error("flags not cleared by read");
    pf_set_a: assert property (pf_rise |=> flags_w[B_PF_FLAG] ##1 flags_w[B_PF_FLAG]
        || $past(rd_flags))
        else $error("power-fail flag not set");
    flags_reset_a: assert property ($fell(srst) |-> flags_w == RST_TBL[0])
        else $error("flags reset value wrong");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper data bits not zero");
    trim_bin_a: assert property ((wr && widx == IDX_TRIM)
        |=> trim_w == ($past(wb_dat_i[7:0]) & WMASK[8]))
        else $error("trim not stored as written");
    alm_reset_a: assert property ($fell(srst) |-> bank_r[IDX_ASEC][B_MSEL]
        && bank_r[IDX_ADATE][B_MSEL])
        else $error("alarm select reset wrong");
    date_bcd_a: assert property ((c_hr && !wr) |=> bank_r[IDX_DATE][3:0] <= 4'h9
        && bank_r[IDX_DATE][5:4] <= 2'h3)
        else $error("date not BCD after step");
    alm_field_a: assert property (alm_rise |-> (bank_r[IDX_ASEC][B_MSEL]
        || bank_r[IDX_ASEC][6:0] == bank_r[IDX_SEC][6:0]) && (bank_r[IDX_AMIN][B_MSEL]
        || bank_r[IDX_AMIN][6:0] == bank_r[IDX_MIN][6:0]) ##1 flags_w[B_ALM_FLAG])
        else $error("alarm flag set with field differing");
    alm_off_a: assert property ((&{bank_r[IDX_ASEC][7], bank_r[IDX_AMIN][7],
        bank_r[IDX_AHR][7], bank_r[IDX_ADATE][7]}) |-> !alm_match)
        else $error("alarm matched while disabled");
    sec_wrap_a: assert property ((c_sec && !wr) |=> bank_r[IDX_SEC] == BCD_00)
        else $error("seconds did not wrap");
    unmapped_a: assert property ((req && !hit && !wb_we_i)
        |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("unmapped read not answered with zero");

    alm_fire_c: cover property (alm_rise ##1 irq_o);
    dog_fire_c: cover property (dog_exp ##1 flags_w[B_DOG_FLAG]);
    flag_read_c: cover property (flags_w[B_ALM_FLAG] && rd_flags ##1 !flags_w[B_ALM_FLAG]);
    day_roll_c: cover property (c_day);
endmodule : rtcb_top
`default_nettype wire

/* File: bench/rtcb_host.sv */
// Host bus master model that issues classic Wishbone cycles
`timescale 1ns/100ps
`default_nettype none
module rtcb_host (
    // Clock
    input  wire logic                       clk_sys,
    // Wishbone master side
    output var  logic [rtcb_pkg::ADR_W-1:0] wb_adr,
    output var  logic [31:0]                wb_dat,
    output var  logic [3:0]                 wb_sel,
    output var  logic                       wb_we,
    output var  logic                       wb_cyc,
    output var  logic                       wb_stb,
    // Slave answer
    input  wire logic [31:0]                wb_rdat,
    input  wire logic                       wb_ack
);
    import rtcb_pkg::*;

    // Idle bus from time zero
    initial begin
        wb_adr = '0;
        wb_dat = '0;
        wb_sel = '0;
        wb_we  = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
    end

    // One classic cycle; everything holds until ack is sampled high
    task automatic cycle(input logic [ADR_W-1:0] a, input logic w,
                         input logic [3:0] s, input logic [31:0] d,
                         output logic [31:0] q);
        @(posedge clk_sys);
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= s;
        wb_we  <= w;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        @(posedge clk_sys);
        while (wb_ack !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        // Released lines show no stale value
        wb_adr <= ~a;
        wb_dat <= ~d;
    endtask : cycle
endmodule : rtcb_host
`default_nettype wire

/* File: bench/tb_rtcb_register_bank_flags.sv */
// Self-checking bench for the clock register bank
`timescale 1ns/100ps
`default_nettype none
module tb_rtcb_register_bank_flags;
    import rtcb_pkg::*;
    localparam int SEC_T = 2000;   // Shortened second
    localparam int LIMIT = 40000;  // Cycle ceiling for the run
    logic             clk_sys, srst, pwr_fail, osc_fail, irq_o;
    logic [ADR_W-1:0] wb_adr;
    logic [31:0]      wb_dat, wb_rdat, q;
    logic [3:0]       wb_sel;
    logic             wb_we, wb_cyc, wb_stb, wb_ack;
    int               n_fail = 0, tests_run = 0, cyc_cnt = 0;
    // Expected reset image, flags register first
    logic [7:0]       rst_img [16] = '{8'h10, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h08,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

    // Clock source
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;

    rtcb_top #(.SEC_CYC_P(SEC_T), .DOG_CYC_P(4)) dut_u (
        .clk_sys(clk_sys), .srst(srst), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pwr_fail(pwr_fail),
        .osc_fail(osc_fail), .irq_o(irq_o));
    rtcb_host host_u (
        .clk_sys(clk_sys), .wb_adr(wb_adr), .wb_dat(wb_dat), .wb_sel(wb_sel),
        .wb_we(wb_we), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_rdat(wb_rdat),
        .wb_ack(wb_ack));

    // Byte address of a bank register
    function automatic logic [ADR_W-1:0] addr(input int off);
        return {IDX_FLAGS + 17'(off), 2'b00};
    endfunction : addr

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : check

    // Register write with upper lanes zero
    task automatic wr(input int off, input logic [7:0] d);
        host_u.cycle(addr(off), 1'b1, 4'h1, {24'h0, d}, q);
    endtask : wr

    // Register read compared over the whole word
    task automatic rd(input int off, input logic [7:0] e);
        host_u.cycle(addr(off), 1'b0, 4'h1, 32'h0, q);
        check($sformatf("register %0d", off), {24'h0, e}, q);
    endtask : rd

    // Bounded wait for the interrupt level
    task automatic wait_irq(input logic exp, input int lim);
        int k;
        k = 0;
        while (irq_o !== exp && k < lim) begin
            @(posedge clk_sys);
            k++;
        end
        check("irq_o", {31'h0, exp}, {31'h0, irq_o});
    endtask : wait_irq

    // One-cycle event on power-fail or oscillator-fail input
    task automatic pulse(input logic pf);
        @(posedge clk_sys);
        if (pf) begin
            pwr_fail <= 1'b1;
        end else begin
            osc_fail <= 1'b1;
        end
        @(posedge clk_sys);
        pwr_fail <= 1'b0;
        osc_fail <= 1'b0;
    endtask : pulse

    // Midnight rollover from 23:59:59 with the given calendar
    task automatic roll(input logic [7:0] d, m, y, w, ed, em, ey, ew);
        int k;
        k = 0;
        wr(8, 8'h80);
        wr(9, 8'h59);
        wr(10, 8'h59);
        wr(11, 8'h23);
        wr(12, w);
        wr(13, d);
        wr(14, m);
        wr(15, y);
        wr(8, 8'h00);
        q = 32'h59;
        while (q[7:0] === 8'h59 && k < SEC_T) begin
            host_u.cycle(addr(9), 1'b0, 4'h1, 32'h0, q);
            k++;
        end
        wr(8, 8'h80);
        rd(9, 8'h00);
        rd(10, 8'h00);
        rd(11, 8'h00);
        rd(12, ew);
        rd(13, ed);
        rd(14, em);
        rd(15, ey);
        $display("test rollover done");
    endtask : roll

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // Hang guard
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == LIMIT) begin
            n_fail++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        srst     = 1'b1;
        pwr_fail = 1'b0;
        osc_fail = 1'b0;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd(i, rst_img[i]);
        end
        check("irq_o after reset", 32'h0, {31'h0, irq_o});
        $display("test reset done");
        // Oscillator-fail flag: write-one clear, not read clear
        wr(0, 8'h10);
        rd(0, 8'h00);
        pulse(1'b0);
        rd(0, 8'h10);
        rd(0, 8'h10);
        wr(0, 8'h10);
        $display("test oscillator flag done");
        // Power-fail flag masked, then enabled, then read clear
        pulse(1'b1);
        repeat (3) @(posedge clk_sys);
        check("irq_o masked", 32'h0, {31'h0, irq_o});
        wr(6, 8'h28);
        wait_irq(1'b1, 8);
        rd(0, 8'h20);
        wait_irq(1'b0, 8);
        rd(0, 8'h00);
        $display("test power fail done");
        // Upper lanes, byte select and addresses below the bank
        host_u.cycle(addr(12), 1'b1, 4'h1, 32'hffffff05, q);
        rd(12, 8'h05);
        host_u.cycle(addr(12), 1'b1, 4'he, 32'h00000003, q);
        rd(12, 8'h05);
        host_u.cycle(19'h00000, 1'b1, 4'h1, 32'h000000ff, q);
        host_u.cycle(19'h00000, 1'b0, 4'h1, 32'h0, q);
        check("below bank", 32'h0, q);
        $display("test bus decode done");
        // Watchdog timeout flag and interrupt
        wr(6, 8'h88);
        wr(7, 8'h02);
        wait_irq(1'b1, 60);
        wr(7, 8'h00);
        rd(0, 8'h80);
        wait_irq(1'b0, 8);
        // Lock keeps the value, strobe reads back zero
        wr(7, 8'hc5);
        rd(7, 8'h40);
        wr(7, 8'h00);
        $display("test watchdog done");
        // All match-select bits set: no alarm
        wr(6, 8'h48);
        repeat (3 * SEC_T) @(posedge clk_sys);
        check("irq_o alarm off", 32'h0, {31'h0, irq_o});
        rd(0, 8'h00);
        $display("test alarm disabled done");
        // Seconds-only match, minutes excluded by select bit
        wr(9, 8'h00);
        wr(0, 8'h02);
        wr(2, 8'h03);
        wr(3, 8'hc5);
        wr(0, 8'h00);
        wait_irq(1'b1, 4 * SEC_T);
        rd(9, 8'h03);
        rd(0, 8'h40);
        $display("test alarm match done");
        roll(8'h31, 8'h12, 8'h99, 8'h07, 8'h01, 8'h01, 8'h00, 8'h01);
        roll(8'h09, 8'h05, 8'h24, 8'h03, 8'h10, 8'h05, 8'h24, 8'h04);
        print_verdict();
    end
endmodule : tb_rtcb_register_bank_flags
`default_nettype wire
